// *** verilog/sgc_top.sv ***
// Socket global control register shared by both card sockets.
// Assumes a byte register port, a global reset pin, a bus reset pin and card cycle requests.
`timescale 1ns/1ns
module sgc_top
   import sgc_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic global_reset_in_n_i,
   input wire logic bus_reset_n_i,
   input wire logic [11:0] addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] wdata_i,
   input wire logic card_cycle_i,
   input wire logic card_a_irq_i,
   input wire logic card_b_irq_i,
   input wire logic csc_event_i,
   input wire logic csc_read_i,
   input wire logic cd_flag_wr1_i,
   output logic [7:0] rdata_o,
   output logic card_a_irq_level_sel_o,
   output logic card_b_irq_level_sel_o,
   output logic status_change_irq_level_sel_o,
   output logic flag_clear_writeback_sel_o,
   output logic card_output_sleep_en_o,
   output logic card_out_en_o,
   output logic csc_flag_clear_o,
   output logic forced_detect_irq_clr_o,
   output logic card_a_irq_o,
   output logic card_b_irq_o,
   output logic csc_irq_o
);
   import sgc_pkg::*;
   // ==========================================================
   // Reset pin and card cycle synchronisation
   sgc_if rst_if ();
   logic [2:0] sync_q;
   sgc_sync u_sync (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .d_i({card_cycle_i, bus_reset_n_i, global_reset_in_n_i}),
      .q_o(sync_q)
   );
   assign rst_if.global_reset_in_n = sync_q[0];
   logic bus_rst_n;
   logic cyc_s;
   assign bus_rst_n = sync_q[1];
   assign cyc_s = sync_q[2];
   // ==========================================================
   // Register
   logic [7:0] ctl_reg;
   logic [7:0] ctl_next;
   logic hit;
   assign hit = (addr_i == SGC_OFF_MAIN) || (addr_i == SGC_OFF_CARD_A) ||
                (addr_i == SGC_OFF_CARD_B);
   always_comb
   begin
      ctl_next = ctl_reg;
      if (wr_i && hit)
      begin
         ctl_next = wdata_i & SGC_RW_MASK;
      end
      // Bus reset leaves the low three bits alone; those survive until global reset
      if (!bus_rst_n)
      begin
         ctl_next[SGC_BIT_A_LVL] = 1'b0;
         ctl_next[SGC_BIT_B_LVL] = 1'b0;
      end
      if (!rst_if.global_reset_in_n)
      begin
         ctl_next = SGC_RESET_VAL;
      end
   end
   // ==========================================================
   // Outputs
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [4:0] mode_reg;
   logic [4:0] mode_next;
   logic csc_clr_reg;
   logic csc_clr_next;
   logic fd_clr_reg;
   logic fd_clr_next;
   logic [2:0] irq_reg;
   logic [2:0] irq_next;
   logic [2:0] irq_dly_reg;
   logic oe_reg;
   logic oe_next;
   sgc_state_t st_reg;
   sgc_state_t st_next;
   always_comb
   begin
      rdata_next = (rd_i && hit) ? ctl_reg : SGC_ZERO_BYTE;
      mode_next = ctl_reg[4:0];
      // Read clears the status change flag only in read-clear mode; forced detect clears only on a writeback
      csc_clr_next = ctl_reg[SGC_BIT_WRBACK] ? cd_flag_wr1_i : csc_read_i;
      fd_clr_next = ctl_reg[SGC_BIT_WRBACK] && cd_flag_wr1_i;
      // Level mode follows the source; edge mode gives one pulse per rising edge
      irq_next[0] = ctl_reg[SGC_BIT_A_LVL] ? card_a_irq_i :
                    (card_a_irq_i && !irq_dly_reg[0]);
      irq_next[1] = ctl_reg[SGC_BIT_B_LVL] ? card_b_irq_i :
                    (card_b_irq_i && !irq_dly_reg[1]);
      irq_next[2] = ctl_reg[SGC_BIT_CSC_LVL] ? csc_event_i :
                    (csc_event_i && !irq_dly_reg[2]);
      st_next = st_reg;
      unique case (st_reg)
         SGC_IDLE:
         begin
            if (cyc_s)
            begin
               st_next = SGC_ACTIVE;
            end
         end
         SGC_ACTIVE:
         begin
            if (!cyc_s)
            begin
               st_next = SGC_IDLE;
            end
         end
         default:
         begin
            st_next = SGC_IDLE;
         end
      endcase
      // Sleep drives only while a card cycle is active
      oe_next = !ctl_reg[SGC_BIT_SLEEP] || (st_next == SGC_ACTIVE);
   end
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ctl_reg <= SGC_RESET_VAL;
         rdata_reg <= SGC_ZERO_BYTE;
         mode_reg <= 5'h00;
         csc_clr_reg <= 1'b0;
         fd_clr_reg <= 1'b0;
         irq_reg <= 3'h0;
         irq_dly_reg <= 3'h0;
         oe_reg <= 1'b1;
         st_reg <= SGC_IDLE;
      end
      else
      begin
         ctl_reg <= ctl_next;
         rdata_reg <= rdata_next;
         mode_reg <= mode_next;
         csc_clr_reg <= csc_clr_next;
         fd_clr_reg <= fd_clr_next;
         irq_reg <= irq_next;
         irq_dly_reg <= {csc_event_i, card_b_irq_i, card_a_irq_i};
         oe_reg <= oe_next;
         st_reg <= st_next;
      end
   end
   assign rdata_o = rdata_reg;
   assign card_output_sleep_en_o = mode_reg[SGC_BIT_SLEEP];
   assign status_change_irq_level_sel_o = mode_reg[SGC_BIT_CSC_LVL];
   assign flag_clear_writeback_sel_o = mode_reg[SGC_BIT_WRBACK];
   assign card_a_irq_level_sel_o = mode_reg[SGC_BIT_A_LVL];
   assign card_b_irq_level_sel_o = mode_reg[SGC_BIT_B_LVL];
   assign card_out_en_o = oe_reg;
   assign csc_flag_clear_o = csc_clr_reg;
   assign forced_detect_irq_clr_o = fd_clr_reg;
   assign card_a_irq_o = irq_reg[0];
   assign card_b_irq_o = irq_reg[1];
   assign csc_irq_o = irq_reg[2];
   // ==========================================================
   // Checks
   AST_RD_ZERO: assert property (@(posedge clk_i) disable iff (!nrst_i)
      rdata_o[7:5] == 3'h0) else $error("reserved bits read nonzero");
   AST_WR_MAP: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wr_i && addr_i == SGC_OFF_CARD_B && rst_if.global_reset_in_n && bus_rst_n
      |=> ctl_reg == ($past(wdata_i) & SGC_RW_MASK)) else $error("alias write lost");
   AST_B_LVL: assert property (@(posedge clk_i) disable iff (!nrst_i)
      ctl_reg[SGC_BIT_B_LVL] |=> card_b_irq_o == $past(card_b_irq_i))
      else $error("card B level mode wrong");
   AST_A_EDGE: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !ctl_reg[SGC_BIT_A_LVL] && card_a_irq_i && irq_dly_reg[0] |=> !card_a_irq_o)
      else $error("card A edge repeats");
   AST_RDCLR: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !ctl_reg[SGC_BIT_WRBACK] && csc_read_i |=> csc_flag_clear_o)
      else $error("read did not clear");
   AST_CSC_LVL: assert property (@(posedge clk_i) disable iff (!nrst_i)
      ctl_reg[SGC_BIT_CSC_LVL] && csc_event_i |=> csc_irq_o)
      else $error("status level mode wrong");
   AST_SLEEP: assert property (@(posedge clk_i) disable iff (!nrst_i)
      ctl_reg[SGC_BIT_SLEEP] && st_reg == SGC_IDLE && !cyc_s |=> !card_out_en_o)
      else $error("outputs driven in sleep");
   AST_BUSRST: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !bus_rst_n && rst_if.global_reset_in_n && !wr_i |=> ctl_reg[2:0] == $past(ctl_reg[2:0]))
      else $error("bus reset hit low bits");
   AST_FDCLR: assert property (@(posedge clk_i) disable iff (!nrst_i)
      ctl_reg[SGC_BIT_WRBACK] && cd_flag_wr1_i |=> forced_detect_irq_clr_o)
      else $error("forced detect not cleared");
endmodule

// *** verilog/sgc_pkg.sv ***
// Package for the socket global control register block.
// Assumes a byte-wide register port addressed by a 12-bit socket offset.
package sgc_pkg;
   // ==========================================================
   // Offsets
   localparam logic [11:0] SGC_OFF_MAIN = 12'h81E;
   localparam logic [11:0] SGC_OFF_CARD_A = 12'h01E;
   localparam logic [11:0] SGC_OFF_CARD_B = 12'h05E;
   // ==========================================================
   // Field positions
   localparam int SGC_BIT_SLEEP = 0;
   localparam int SGC_BIT_CSC_LVL = 1;
   localparam int SGC_BIT_WRBACK = 2;
   localparam int SGC_BIT_A_LVL = 3;
   localparam int SGC_BIT_B_LVL = 4;
   localparam logic [7:0] SGC_RESET_VAL = 8'h00;
   localparam logic [7:0] SGC_RW_MASK = 8'h1F;
   localparam logic [7:0] SGC_ZERO_BYTE = 8'h00;
   // Synchroniser rest value: reset pins high, card cycle low, so no fake reset follows nrst_i
   localparam logic [2:0] SGC_SYNC_IDLE = 3'h3;
   typedef enum logic [1:0] {SGC_IDLE, SGC_ACTIVE} sgc_state_t;
endpackage

// *** verilog/sgc_if.sv ***
// Interface carrying the global reset synchroniser output to the main block.
// Assumes one clock domain.
`timescale 1ns/1ns
interface sgc_if;
   logic global_reset_in_n;
   modport src (output global_reset_in_n);
   modport dst (input global_reset_in_n);
endinterface

// *** verilog/sgc_sync.sv ***
// Two-stage synchroniser for pin inputs of the global control block.
// Assumes inputs are asynchronous to clk_i.
`timescale 1ns/1ns
module sgc_sync
   import sgc_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [2:0] d_i,
   output logic [2:0] q_o
);
   logic [2:0] s1_reg;
   logic [2:0] s1_next;
   logic [2:0] s2_reg;
   logic [2:0] s2_next;
   always_comb
   begin
      s1_next = d_i;
      s2_next = s1_reg;
   end
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         s1_reg <= SGC_SYNC_IDLE;
         s2_reg <= SGC_SYNC_IDLE;
      end
      else
      begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
      end
   end
   assign q_o = s2_reg;
endmodule

// *** verif/sgc_card_model.sv ***
// Card-side partner: drives the card cycle and interrupt source lines.
// Assumes the bench sets requests; lines change only at a falling edge.
`timescale 1ns/1ns
module sgc_card_model
(
   input wire logic clk_i,
   input wire logic [3:0] req_i,
   output logic card_cycle_o = 1'b0,
   output logic irq_a_o = 1'b0,
   output logic irq_b_o = 1'b0,
   output logic csc_o = 1'b0
);
   // ==========================================
   // Lines are levels held until the next request
   always @(negedge clk_i)
   begin
      {csc_o, irq_b_o, irq_a_o, card_cycle_o} <= req_i;
   end
endmodule

// *** verif/tb.sv ***
// Testbench for the socket global control register.
// Assumes the card partner model and a 10 MHz clock.
`timescale 1ns/1ns
module tb;
   import sgc_pkg::*;
   logic clk_i = 1'b0, nrst_i = 1'b0, global_reset_in_n = 1'b1, brst_n = 1'b1;
   logic [11:0] addr = 12'h000;
   logic [7:0] wdata = 8'h00, rdata;
   logic wr = 1'b0, rd = 1'b0, csc_rd = 1'b0, cd_wr1 = 1'b0;
   logic [3:0] req = 4'h0;
   logic cyc_l, ia, ib, ic, a_sel, b_sel, c_sel, wb, slp, oe, clr, fclr, a_o, b_o, c_o;
   logic [4:0] ev;
   int hi[5];
   int cyc = 0, n_mismatch = 0, cmp_count = 0;
   assign ev = {fclr, clr, c_o, b_o, a_o};
   initial forever #50 clk_i = ~clk_i;
   sgc_card_model card_u (.clk_i(clk_i), .req_i(req), .card_cycle_o(cyc_l),
      .irq_a_o(ia), .irq_b_o(ib), .csc_o(ic));
   sgc_top dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .global_reset_in_n_i(global_reset_in_n),
      .bus_reset_n_i(brst_n), .addr_i(addr), .wr_i(wr), .rd_i(rd), .wdata_i(wdata),
      .card_cycle_i(cyc_l), .card_a_irq_i(ia), .card_b_irq_i(ib), .csc_event_i(ic),
      .csc_read_i(csc_rd), .cd_flag_wr1_i(cd_wr1), .rdata_o(rdata),
      .card_a_irq_level_sel_o(a_sel), .card_b_irq_level_sel_o(b_sel),
      .status_change_irq_level_sel_o(c_sel), .flag_clear_writeback_sel_o(wb),
      .card_output_sleep_en_o(slp), .card_out_en_o(oe), .csc_flag_clear_o(clr),
      .forced_detect_irq_clr_o(fclr), .card_a_irq_o(a_o), .card_b_irq_o(b_o),
      .csc_irq_o(c_o));
   // ==========================================
   // Pulse counters; a one-cycle pulse shows up as exactly one
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      for (int i = 0; i < 5; i++)
         hi[i] <= hi[i] + int'(ev[i]);
      if (cyc == 3000)
      begin
         n_mismatch++;
         finish_test();
      end
   end
   task automatic finish_test();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Counters restart at the start of a wait so the pulses inside it are kept
   task automatic idle(input int n);
      for (int i = 0; i < 5; i++)
         hi[i] = 0;
      repeat (n) @(negedge clk_i);
   endtask
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk_i);
      wr = 1'b0;
      idle(2);
   endtask
   task automatic rd_reg(input logic [11:0] a, input logic [7:0] exp, input string nm);
      @(negedge clk_i);
      addr = a;
      rd = 1'b1;
      @(negedge clk_i);
      rd = 1'b0;
      // Read data stands for one cycle only
      chk(nm, exp, rdata);
   endtask
   task automatic pls(ref logic s);
      @(negedge clk_i);
      s = 1'b1;
      @(negedge clk_i);
      s = 1'b0;
      repeat (3) @(negedge clk_i);
   endtask
   // ==========================================
   // Main sequence
   initial
   begin
      idle(4);
      nrst_i = 1'b1;
      rd_reg(SGC_OFF_MAIN, SGC_RESET_VAL, "reset value");
      chk("out enable at reset", 8'h01, {7'h00, oe});
      wr_reg(SGC_OFF_MAIN, 8'hFF);
      rd_reg(SGC_OFF_CARD_A, SGC_RW_MASK, "card A alias");
      rd_reg(SGC_OFF_CARD_B, SGC_RW_MASK, "card B alias");
      rd_reg(12'h81F, SGC_ZERO_BYTE, "unmapped");
      chk("modes", 8'h1F, {3'h0, b_sel, a_sel, wb, c_sel, slp});
      chk("sleep floats", 8'h00, {7'h00, oe});
      req <= 4'hF;
      idle(7);
      chk("card access wakes", 8'h01, {7'h00, oe});
      chk("level irqs in sleep", 8'h07, {5'h00, c_o, b_o, a_o});
      req <= 4'h0;
      idle(7);
      chk("back to float", 8'h00, {7'h00, oe});
      pls(cd_wr1);
      chk("writeback clear", 8'h01, 8'(hi[3]));
      chk("forced detect clear", 8'h01, 8'(hi[4]));
      pls(csc_rd);
      chk("read keeps flags", 8'h01, 8'(hi[3]));
      brst_n = 1'b0;
      idle(4);
      brst_n = 1'b1;
      idle(4);
      rd_reg(SGC_OFF_MAIN, 8'h07, "bus reset");
      wr_reg(SGC_OFF_CARD_B, 8'h00);
      req <= 4'hE;
      idle(7);
      chk("edge status once", 8'h01, 8'(hi[2]));
      chk("edge A once", 8'h01, 8'(hi[0]));
      chk("edge B once", 8'h01, 8'(hi[1]));
      chk("awake without sleep", 8'h01, {7'h00, oe});
      pls(csc_rd);
      chk("read clear", 8'h01, 8'(hi[3]));
      req <= 4'h0;
      wr_reg(SGC_OFF_MAIN, 8'hFF);
      global_reset_in_n = 1'b0;
      idle(4);
      global_reset_in_n = 1'b1;
      idle(4);
      rd_reg(SGC_OFF_MAIN, SGC_RESET_VAL, "global reset");
      finish_test();
   end
endmodule
